// ===== axreg_flag.sv
// Sticky status flag: hardware sets, software clears.
// Assumes set and clear are synchronous single-cycle levels.
`timescale 1ns/1ps
module axreg_flag (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clr,
  input wire logic i_hold,
  output logic o_flag
);
  logic flag_reg;
  logic flag_next;

  // Set beats clear; clear refused while condition still present
  always_comb begin
    flag_next = flag_reg;
    if (i_clr && !i_hold) begin
      flag_next = 1'b0;
    end
    if (i_set) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= axreg_pkg::AXREG_FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;

  chk_set_wins: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_set |=> o_flag)
    else $error("flag set lost");
endmodule // axreg_flag

// ===== axreg_pkg.sv
// Package for the auxiliary regulator control block.
// Constants and mode encodings shared by the top and its helper.
package axreg_pkg;

  // Chip operating modes, one-hot
  typedef enum logic [5:0] {
    AXREG_MODE_INIT     = 6'h01,
    AXREG_MODE_NORMAL   = 6'h02,
    AXREG_MODE_STOP     = 6'h04,
    AXREG_MODE_SLEEP    = 6'h08,
    AXREG_MODE_RESTART  = 6'h10,
    AXREG_MODE_FAILSAFE = 6'h20
  } axreg_mode_t;

  // Configuration lock states, one-hot
  typedef enum logic [2:0] {
    AXREG_CFG_NONE  = 3'h1,
    AXREG_CFG_STAND = 3'h2,
    AXREG_CFG_SHARE = 3'h4
  } axreg_cfg_t;

  // Reset values
  localparam logic AXREG_FLAG_RST = 1'h0;
  localparam logic [1:0] AXREG_SYNC_RST = 2'h0;
  // Voltage select codes
  localparam logic AXREG_VSEL_3V3 = 1'h0;
  localparam logic AXREG_VSEL_1V8 = 1'h1;

endpackage

// ===== axreg_top.sv
// Auxiliary regulator control: configuration lock, mode-based enable,
// supply undervoltage switch-off, stop-mode power stages and flags.
// Assumes all inputs synchronous to i_core_clk; i_rst_n is power-on reset.
`timescale 1ns/1ps
module axreg_top (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_soft_rst,
  input wire logic [5:0] i_mode,
  input wire logic i_standalone_enable,
  input wire logic i_load_share_enable,
  input wire logic i_aux_voltage_select,
  input wire logic i_keep_on_below_battery_uv,
  input wire logic i_load_share_stop_keep_on,
  input wire logic i_battery_below_uv,
  input wire logic i_shunt_at_threshold,
  input wire logic i_aux_output_uv,
  input wire logic i_base_above_rise,
  input wire logic i_base_below_fall,
  input wire logic i_oc_flag_clear,
  input wire logic i_uv_flag_clear,
  output logic o_aux_enable,
  output logic o_aux_voltage_1v8,
  output logic o_current_limit,
  output logic o_low_power_on,
  output logic o_high_power_on,
  output logic o_standalone_locked,
  output logic o_load_share_locked,
  output logic o_spi_error,
  output logic o_aux_overcurrent_flag,
  output logic o_aux_undervoltage_flag
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  axreg_pkg::axreg_cfg_t cfg_reg, cfg_next;
  logic sa_on_reg, sa_on_next;
  logic vsel_reg, vsel_next;
  logic en_reg, en_next;
  logic hp_reg, hp_next;
  logic lp_reg, lp_next;
  logic err_reg, err_next;
  logic ls_bit_reg; // Last load-share bit, to catch it being dropped
  logic is_sa, is_ls, mode_on;

  // Two-stage reset release; the first stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= axreg_pkg::AXREG_SYNC_RST;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign is_sa = (cfg_reg == axreg_pkg::AXREG_CFG_STAND);
  assign is_ls = (cfg_reg == axreg_pkg::AXREG_CFG_SHARE);

  // Configuration lock and control bits. Soft reset is ignored on purpose:
  // the lock must survive it, only power-on reset clears it.
  always_comb begin
    cfg_next = cfg_reg;
    sa_on_next = sa_on_reg;
    vsel_next = vsel_reg;
    err_next = 1'b0;
    unique case (cfg_reg)
      axreg_pkg::AXREG_CFG_NONE: begin
        if (i_load_share_enable) begin
          cfg_next = axreg_pkg::AXREG_CFG_SHARE;
        end else if (i_standalone_enable &&
                     i_mode == axreg_pkg::AXREG_MODE_NORMAL) begin
          cfg_next = axreg_pkg::AXREG_CFG_STAND;
          sa_on_next = 1'b1;
        end
      end
      axreg_pkg::AXREG_CFG_STAND: begin
        // On/off still steerable; load-share request silently dropped
        if (i_mode == axreg_pkg::AXREG_MODE_NORMAL) begin
          sa_on_next = i_standalone_enable;
        end
      end
      axreg_pkg::AXREG_CFG_SHARE: begin
        if (i_standalone_enable || (!i_load_share_enable && ls_bit_reg)) begin
          err_next = 1'b1;
        end
      end
    endcase
    if (i_mode == axreg_pkg::AXREG_MODE_NORMAL) begin
      vsel_next = i_aux_voltage_select;
    end
  end

  // Mode table: what the regulator does per chip mode
  always_comb begin
    mode_on = 1'b0;
    unique case (i_mode)
      axreg_pkg::AXREG_MODE_INIT: mode_on = 1'b0;
      axreg_pkg::AXREG_MODE_NORMAL: mode_on = is_ls || (is_sa && sa_on_reg);
      axreg_pkg::AXREG_MODE_STOP:
        mode_on = (is_ls && i_load_share_stop_keep_on)
                  || (is_sa && sa_on_reg);
      axreg_pkg::AXREG_MODE_SLEEP: mode_on = is_sa && sa_on_reg;
      axreg_pkg::AXREG_MODE_RESTART: mode_on = is_ls || (is_sa && sa_on_reg);
      axreg_pkg::AXREG_MODE_FAILSAFE: mode_on = 1'b0;
      default: mode_on = 1'b0;
    endcase
  end

  // Enable with battery undervoltage cut-off and power stage choice
  always_comb begin
    en_next = mode_on &&
              (!i_battery_below_uv || i_keep_on_below_battery_uv);
    lp_next = 1'b0;
    hp_next = 1'b0;
    if (en_next) begin
      if (i_mode == axreg_pkg::AXREG_MODE_STOP) begin
        lp_next = 1'b1;
        // Hysteresis between the two base-current thresholds
        if (i_base_above_rise) begin
          hp_next = 1'b1;
        end else if (i_base_below_fall) begin
          hp_next = 1'b0;
        end else begin
          hp_next = hp_reg;
        end
      end else begin
        hp_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= axreg_pkg::AXREG_CFG_NONE;
      sa_on_reg <= 1'b0;
      vsel_reg <= axreg_pkg::AXREG_VSEL_3V3;
      en_reg <= 1'b0;
      hp_reg <= 1'b0;
      lp_reg <= 1'b0;
      err_reg <= 1'b0;
      ls_bit_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      sa_on_reg <= sa_on_next;
      vsel_reg <= vsel_next;
      en_reg <= en_next;
      hp_reg <= hp_next;
      lp_reg <= lp_next;
      err_reg <= err_next;
      ls_bit_reg <= i_load_share_enable;
    end
  end

  // Flags only in stand-alone configuration
  axreg_flag u_oc_flag (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_set(is_sa && en_reg && i_shunt_at_threshold),
    .i_clr(i_oc_flag_clear),
    .i_hold(i_shunt_at_threshold),
    .o_flag(o_aux_overcurrent_flag)
  );
  axreg_flag u_uv_flag (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_set(is_sa && en_reg && i_aux_output_uv),
    .i_clr(i_uv_flag_clear),
    .i_hold(1'b0),
    .o_flag(o_aux_undervoltage_flag)
  );

  assign o_aux_enable = en_reg;
  assign o_aux_voltage_1v8 = is_sa && vsel_reg;
  assign o_current_limit = is_sa && en_reg && i_shunt_at_threshold;
  assign o_low_power_on = lp_reg;
  assign o_high_power_on = hp_reg;
  assign o_standalone_locked = is_sa;
  assign o_load_share_locked = is_ls;
  assign o_spi_error = err_reg;

  // Lock, error and mode checks; soft reset must never reach the lock
  chk_lock_holds: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (cfg_reg != axreg_pkg::AXREG_CFG_NONE) |=> $stable(cfg_reg))
    else $error("configuration lock changed");
  chk_soft_keep: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    i_soft_rst |=> (cfg_reg == $past(cfg_reg)))
    else $error("soft reset touched the lock");
  chk_ls_error: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (is_ls && i_standalone_enable) |=> o_spi_error)
    else $error("load share change not flagged");
  chk_ls_drop: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (is_ls && ls_bit_reg && !i_load_share_enable) |=> o_spi_error)
    else $error("load share bit drop not flagged");
  chk_sa_no_error: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    is_sa |=> !o_spi_error)
    else $error("stand-alone raised error");
  chk_vsel_ls: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    is_ls |-> !o_aux_voltage_1v8)
    else $error("voltage select used in load share");
  chk_uv_cut: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_battery_below_uv && !i_keep_on_below_battery_uv) |=> !o_aux_enable)
    else $error("battery undervoltage not cut off");
  chk_fs_off: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_mode == axreg_pkg::AXREG_MODE_FAILSAFE) |=> !o_aux_enable)
    else $error("on in fail-safe");
  chk_ls_no_oc: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    is_ls |-> !o_current_limit)
    else $error("limit in load share");
  chk_stop_ls: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (is_ls && i_mode == axreg_pkg::AXREG_MODE_STOP &&
     !i_load_share_stop_keep_on) |=> !o_aux_enable)
    else $error("load share ran in stop");
  chk_normal_hp: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (en_next && i_mode == axreg_pkg::AXREG_MODE_NORMAL)
    |=> (o_high_power_on && !o_low_power_on))
    else $error("normal mode stage wrong");
endmodule // axreg_top

// ===== tb_axreg_top.sv
// Self-checking bench for the auxiliary regulator control top.
// Assumes axreg_pkg is compiled first; the bench drives all ports itself.
`timescale 1ns/1ps
module tb_axreg_top;
  localparam logic [5:0] M_INI = axreg_pkg::AXREG_MODE_INIT;
  localparam logic [5:0] M_NRM = axreg_pkg::AXREG_MODE_NORMAL;
  localparam logic [5:0] M_STP = axreg_pkg::AXREG_MODE_STOP;
  localparam logic [5:0] M_SLP = axreg_pkg::AXREG_MODE_SLEEP;
  localparam logic [5:0] M_RST = axreg_pkg::AXREG_MODE_RESTART;
  localparam logic [5:0] M_FS = axreg_pkg::AXREG_MODE_FAILSAFE;
  logic clk, rst_n, srst, sa, ls, vs, kp, sk, bat, sh, auv, rise, fall;
  logic occ, uvc, en, v18, cl, lp, hp, sal, lsl, err, ocf, uvf;
  logic [5:0] mode;
  logic [5:0] walk [4] = '{M_SLP, M_RST, M_INI, M_FS};
  int fails = 0, checks_done = 0, errs = 0, cfg, sa_on, vsel_r;

  axreg_top DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_soft_rst(srst),
    .i_mode(mode), .i_standalone_enable(sa), .i_load_share_enable(ls),
    .i_aux_voltage_select(vs), .i_keep_on_below_battery_uv(kp),
    .i_load_share_stop_keep_on(sk), .i_battery_below_uv(bat),
    .i_shunt_at_threshold(sh), .i_aux_output_uv(auv),
    .i_base_above_rise(rise), .i_base_below_fall(fall),
    .i_oc_flag_clear(occ), .i_uv_flag_clear(uvc), .o_aux_enable(en),
    .o_aux_voltage_1v8(v18), .o_current_limit(cl), .o_low_power_on(lp),
    .o_high_power_on(hp), .o_standalone_locked(sal),
    .o_load_share_locked(lsl), .o_spi_error(err),
    .o_aux_overcurrent_flag(ocf), .o_aux_undervoltage_flag(uvf));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Error is a one-cycle pulse, so count it at every edge
  always @(posedge clk) if (err === 1'b1) errs++;

  task chk(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Reference model: lock on first pick, stand-alone state held off normal
  function logic exp_en();
    if (bat && !kp) return 1'b0;
    if (cfg == 1) return (mode == M_INI || mode == M_FS) ? 1'b0 : sa_on[0];
    if (cfg == 2) return mode == M_NRM || mode == M_RST || (mode == M_STP && sk);
    return 1'b0;
  endfunction

  // Let registered outputs land, then step the model and compare
  task go;
    repeat (4) @(posedge clk);
    @(negedge clk);
    if (cfg == 0 && ls) cfg = 2;
    else if (cfg == 0 && sa && mode == M_NRM) cfg = 1;
    if (mode == M_NRM) begin
      sa_on = sa;
      vsel_r = vs;
    end
    chk(en, exp_en(), "enable");
    chk(v18, cfg == 1 && vsel_r[0], "voltage select");
    chk(sal, cfg == 1, "stand-alone lock");
    chk(lsl, cfg == 2, "load-share lock");
    chk(cl, cfg == 1 && exp_en() && sh, "current limit");
  endtask

  // Power-on reset; the model forgets its lock too
  task por;
    {srst, sa, ls, vs, kp, sk, bat, sh, auv, rise, fall, occ, uvc} <= '0;
    rst_n <= 1'b0;
    mode <= M_INI;
    cfg = 0;
    sa_on = 0;
    vsel_r = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    go;
  endtask

  task mode_walk;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) mode <= walk[i];
      go;
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is about one microsecond; this limit only catches a hang
  initial begin
    #100000;
    fails++;
    end_of_test;
  end

  // Stand-alone pass, then a fresh power-up in load sharing
  initial begin
    void'($urandom(50));
    por;
    @(posedge clk) mode <= M_NRM;
    @(posedge clk) sa <= 1'b1;
    vs <= 1'($urandom);
    go;
    chk(hp, 1'b1, "high stage normal");
    chk(lp, 1'b0, "low stage normal");
    @(posedge clk) srst <= 1'b1;
    go;
    @(posedge clk) ls <= 1'b1;
    go;
    chk(errs == 0, 1'b1, "silent refusal");
    @(posedge clk) {ls, srst, sa} <= 3'b000;
    go;
    @(posedge clk) sa <= 1'b1;
    go;
    @(posedge clk) vs <= ~vs;
    go;
    @(posedge clk) {sh, occ} <= 2'b11;
    go;
    chk(ocf, 1'b1, "oc flag held");
    @(posedge clk) sh <= 1'b0;
    go;
    chk(ocf, 1'b0, "oc flag cleared");
    @(posedge clk) {occ, auv} <= 2'b01;
    go;
    chk(uvf, 1'b1, "uv flag");
    @(posedge clk) {auv, uvc} <= 2'b01;
    go;
    chk(uvf, 1'b0, "uv cleared");
    @(posedge clk) {uvc, bat} <= 2'b01;
    go;
    @(posedge clk) kp <= 1'b1;
    go;
    @(posedge clk) {bat, kp, mode} <= {2'b00, M_STP};
    go;
    chk(lp, 1'b1, "low stage stop");
    @(posedge clk) fall <= 1'b1;
    go;
    chk(hp, 1'b0, "high stage dropped");
    @(posedge clk) {fall, rise} <= 2'b01;
    go;
    chk(hp, 1'b1, "high stage added");
    @(posedge clk) rise <= 1'b0;
    go;
    chk(hp, 1'b1, "high stage kept");
    mode_walk;
    @(posedge clk) por;
    @(posedge clk) {mode, ls, vs} <= {M_NRM, 2'b11};
    go;
    @(posedge clk) sa <= 1'b1;
    @(posedge clk) sa <= 1'b0;
    go;
    chk(errs == 1, 1'b1, "change flagged");
    @(posedge clk) ls <= 1'b0;
    @(posedge clk) ls <= 1'b1;
    go;
    chk(errs == 2, 1'b1, "bit drop flagged");
    @(posedge clk) {sh, auv, occ} <= 3'b110;
    go;
    chk(ocf | uvf, 1'b0, "no share flags");
    @(posedge clk) {sh, auv, mode} <= {2'b00, M_STP};
    go;
    @(posedge clk) mode <= M_NRM;
    go;
    @(posedge clk) {sk, mode} <= {1'b1, M_STP};
    go;
    mode_walk;
    end_of_test;
  end
endmodule // tb_axreg_top
